// [common/bbcc_map.svh]
`ifndef BBCC_MAP_SVH
`define BBCC_MAP_SVH

// register byte addresses
`define BBCC_ADDR_CFG_A 8'h29
`define BBCC_ADDR_CFG_B 8'h2A

// field positions, second register
`define BBCC_EN_CTRL_LSB 0
`define BBCC_EN_CTRL_MSB 2
`define BBCC_DIS_EN_BIT 3

// field positions, first register
`define BBCC_TV_LSB 0
`define BBCC_TV_MSB 5

// values before the one-time-programmed load, and the read value of the unused bits
`define BBCC_CFG_A_RST 8'h00
`define BBCC_CFG_B_RST 4'h0
`define BBCC_UNUSED_RD 4'h0

// target voltage transfer function, millivolts
`define BBCC_TV_BASE_MV 12'h320
`define BBCC_TV_STEP_MV 12'h019

// default target port address, arbitrary
`define BBCC_DEV_ADDR 7'h48

`endif

// [common/bbcc_pkg.sv]
package bbcc_pkg;

    typedef enum logic [3:0] {
        BBCC_IDLE  = 4'h0,
        BBCC_ADDR  = 4'h1,
        BBCC_AACK  = 4'h3,
        BBCC_PTR   = 4'h2,
        BBCC_PACK  = 4'h6,
        BBCC_WDATA = 4'h7,
        BBCC_WACK  = 4'h5,
        BBCC_RDATA = 4'h4,
        BBCC_RACK  = 4'hC,
        BBCC_RLOAD = 4'hD
    } bbcc_state_t;

endpackage

// [hw/bbcc_top.sv]
`timescale 1ns/100ps
`include "bbcc_map.svh"

module bbcc_top #(
    parameter logic [6:0] DEV_ADDR = `BBCC_DEV_ADDR
) (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    input wire logic [7:0] OTP_CFG_A,
    input wire logic [3:0] OTP_CFG_B,
    input wire logic [3:0] SEQ_SLOT_ON,
    input wire logic ONOFF_ON,
    output logic CH0_ENABLE,
    output logic CH0_DISCHARGE,
    output logic [5:0] CH0_TARGET_CODE,
    output logic [11:0] CH0_TARGET_MV
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic scl_meta_reg, scl_sync_reg, scl_prev_reg;
    logic sda_meta_reg, sda_sync_reg, sda_prev_reg;

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            scl_meta_reg <= 1'b1;
            scl_sync_reg <= 1'b1;
            scl_prev_reg <= 1'b1;
            sda_meta_reg <= 1'b1;
            sda_sync_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            scl_meta_reg <= SCL_IN;
            scl_sync_reg <= scl_meta_reg;
            scl_prev_reg <= scl_sync_reg;
            sda_meta_reg <= SDA_IN;
            sda_sync_reg <= sda_meta_reg;
            sda_prev_reg <= sda_sync_reg;
        end
    end

    logic scl_rise, scl_fall, bus_start, bus_stop;
    assign scl_rise = scl_sync_reg & ~scl_prev_reg;
    assign scl_fall = ~scl_sync_reg & scl_prev_reg;
    assign bus_start = scl_sync_reg & scl_prev_reg & sda_prev_reg & ~sda_sync_reg;
    assign bus_stop = scl_sync_reg & scl_prev_reg & ~sda_prev_reg & sda_sync_reg;

    ////////////////////////////////////////////////////////////////////////////
    // target port and register file

    bbcc_pkg::bbcc_state_t state_reg, state_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [7:0] shift_reg, shift_next;
    logic [7:0] ptr_reg, ptr_next;
    logic oe_reg, oe_next;
    logic load_reg, load_next;
    logic [7:0] cfg_a_reg, cfg_a_next;
    logic [3:0] cfg_b_reg, cfg_b_next;
    logic [7:0] rd_byte;

    always_comb begin
        case (ptr_reg)
            `BBCC_ADDR_CFG_A: rd_byte = cfg_a_reg;
            `BBCC_ADDR_CFG_B: rd_byte = {`BBCC_UNUSED_RD, cfg_b_reg};
            default: rd_byte = 8'h00;
        endcase
    end

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        shift_next = shift_reg;
        ptr_next = ptr_reg;
        oe_next = oe_reg;
        load_next = 1'b0;
        cfg_a_next = cfg_a_reg;
        cfg_b_next = cfg_b_reg;
        if (load_reg) begin
            cfg_a_next = OTP_CFG_A;
            cfg_b_next = OTP_CFG_B;
        end
        if (bus_start) begin
            state_next = bbcc_pkg::BBCC_ADDR;
            cnt_next = 4'h0;
            oe_next = 1'b0;
        end else if (bus_stop) begin
            state_next = bbcc_pkg::BBCC_IDLE;
            oe_next = 1'b0;
        end else begin
            case (state_reg)
                bbcc_pkg::BBCC_IDLE: begin
                    oe_next = 1'b0;
                end
                bbcc_pkg::BBCC_ADDR, bbcc_pkg::BBCC_PTR, bbcc_pkg::BBCC_WDATA: begin
                    if (scl_rise && cnt_reg < 4'h8) begin
                        shift_next = {shift_reg[6:0], sda_sync_reg};
                        cnt_next = cnt_reg + 4'h1;
                    end else if (scl_fall && cnt_reg == 4'h8) begin
                        cnt_next = 4'h0;
                        oe_next = 1'b1;
                        if (state_reg == bbcc_pkg::BBCC_ADDR) begin
                            if (shift_reg[7:1] == DEV_ADDR) begin
                                state_next = bbcc_pkg::BBCC_AACK;
                            end else begin
                                state_next = bbcc_pkg::BBCC_IDLE;
                                oe_next = 1'b0;
                            end
                        end else if (state_reg == bbcc_pkg::BBCC_PTR) begin
                            ptr_next = shift_reg;
                            state_next = bbcc_pkg::BBCC_PACK;
                        end else begin
                            if (ptr_reg == `BBCC_ADDR_CFG_A) begin
                                cfg_a_next = shift_reg;
                            end else if (ptr_reg == `BBCC_ADDR_CFG_B) begin
                                cfg_b_next = shift_reg[3:0];
                            end
                            ptr_next = ptr_reg + 8'h01;
                            state_next = bbcc_pkg::BBCC_WACK;
                        end
                    end
                end
                bbcc_pkg::BBCC_AACK: begin
                    if (scl_fall) begin
                        // shift still holds the address byte, read flag in bit 0
                        if (shift_reg[0]) begin
                            shift_next = rd_byte;
                            oe_next = ~rd_byte[7];
                            ptr_next = ptr_reg + 8'h01;
                            state_next = bbcc_pkg::BBCC_RDATA;
                        end else begin
                            oe_next = 1'b0;
                            state_next = bbcc_pkg::BBCC_PTR;
                        end
                    end
                end
                bbcc_pkg::BBCC_PACK, bbcc_pkg::BBCC_WACK: begin
                    if (scl_fall) begin
                        oe_next = 1'b0;
                        state_next = bbcc_pkg::BBCC_WDATA;
                    end
                end
                bbcc_pkg::BBCC_RDATA: begin
                    if (scl_rise) begin
                        cnt_next = cnt_reg + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt_reg == 4'h8) begin
                            cnt_next = 4'h0;
                            oe_next = 1'b0;
                            state_next = bbcc_pkg::BBCC_RACK;
                        end else begin
                            shift_next = {shift_reg[6:0], 1'b0};
                            oe_next = ~shift_reg[6];
                        end
                    end
                end
                bbcc_pkg::BBCC_RACK: begin
                    // a not-acknowledge ends the read; wait for stop
                    if (scl_rise) begin
                        state_next = sda_sync_reg ? bbcc_pkg::BBCC_IDLE : bbcc_pkg::BBCC_RLOAD;
                    end
                end
                bbcc_pkg::BBCC_RLOAD: begin
                    if (scl_fall) begin
                        shift_next = rd_byte;
                        oe_next = ~rd_byte[7];
                        ptr_next = ptr_reg + 8'h01;
                        state_next = bbcc_pkg::BBCC_RDATA;
                    end
                end
                default: begin
                    state_next = bbcc_pkg::BBCC_IDLE;
                    oe_next = 1'b0;
                end
            endcase
        end
    end

    // load flag is a constant at reset; programmed values arrive one edge after release
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            state_reg <= bbcc_pkg::BBCC_IDLE;
            cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            ptr_reg <= 8'h00;
            oe_reg <= 1'b0;
            load_reg <= 1'b1;
            cfg_a_reg <= `BBCC_CFG_A_RST;
            cfg_b_reg <= `BBCC_CFG_B_RST;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            shift_reg <= shift_next;
            ptr_reg <= ptr_next;
            oe_reg <= oe_next;
            load_reg <= load_next;
            cfg_a_reg <= cfg_a_next;
            cfg_b_reg <= cfg_b_next;
        end
    end

    assign SDA_OUT = 1'b0;
    assign SDA_OE = oe_reg;

    ////////////////////////////////////////////////////////////////////////////
    // channel 0 control

    logic [2:0] en_ctrl;
    logic [5:0] tv_code;
    logic ch_on_next, dis_next;
    logic [11:0] mv_next;
    logic ch_on_reg, dis_reg;
    logic [5:0] code_reg;
    logic [11:0] mv_reg;

    assign en_ctrl = cfg_b_reg[`BBCC_EN_CTRL_MSB:`BBCC_EN_CTRL_LSB];
    assign tv_code = cfg_a_reg[`BBCC_TV_MSB:`BBCC_TV_LSB];

    always_comb begin
        case (en_ctrl)
            3'h0, 3'h1, 3'h2, 3'h3: ch_on_next = SEQ_SLOT_ON[en_ctrl[1:0]];
            3'h4, 3'h5: ch_on_next = 1'b0;
            // forced on in controller on states
            3'h6, 3'h7: ch_on_next = ONOFF_ON;
            default: ch_on_next = 1'b0;
        endcase
        // discharge only while off and enabled
        dis_next = cfg_b_reg[`BBCC_DIS_EN_BIT] & ~ch_on_next;
        mv_next = `BBCC_TV_BASE_MV + {6'h00, tv_code} * `BBCC_TV_STEP_MV;
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            ch_on_reg <= 1'b0;
            dis_reg <= 1'b0;
            code_reg <= 6'h00;
            mv_reg <= `BBCC_TV_BASE_MV;
        end else begin
            ch_on_reg <= ch_on_next;
            dis_reg <= dis_next;
            code_reg <= tv_code;
            mv_reg <= mv_next;
        end
    end

    assign CH0_ENABLE = ch_on_reg;
    assign CH0_DISCHARGE = dis_reg;
    assign CH0_TARGET_CODE = code_reg;
    assign CH0_TARGET_MV = mv_reg;

endmodule // bbcc_top

// [bench/bbcc_top_asserts.sv]
`timescale 1ns/100ps
module bbcc_top_chk (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    input wire logic SDA_OUT,
    input wire logic SDA_OE,
    input wire logic [7:0] OTP_CFG_A,
    input wire logic [3:0] OTP_CFG_B,
    input wire logic [3:0] SEQ_SLOT_ON,
    input wire logic ONOFF_ON,
    input wire logic CH0_ENABLE,
    input wire logic CH0_DISCHARGE,
    input wire logic [5:0] CH0_TARGET_CODE,
    input wire logic [11:0] CH0_TARGET_MV
);
    default clocking @(posedge CLOCK);
    endclocking
    default disable iff (RST);
    ////////////////////////////////////////////////////////////////
    chk_mv_linear: assert property (
        CH0_TARGET_MV == 12'h320 + 12'h019 * {6'h00, CH0_TARGET_CODE})
        else $error("target millivolts off the code");
    chk_mv_range: assert property (
        CH0_TARGET_MV >= 12'h320 && CH0_TARGET_MV <= 12'h947)
        else $error("target millivolts out of range");
    chk_dis_when_off: assert property (CH0_DISCHARGE |-> !CH0_ENABLE)
        else $error("discharge while channel on");
    // all slots off: only the forced-on mode may turn on
    chk_en_needs_onoff: assert property (
        $past(SEQ_SLOT_ON) == 4'h0 && CH0_ENABLE |-> $past(ONOFF_ON))
        else $error("channel on without controller on");
    chk_en_needs_slot: assert property (
        CH0_ENABLE && !$past(ONOFF_ON) |-> $past(SEQ_SLOT_ON) != 4'h0)
        else $error("channel on without slot or controller");
    chk_sda_low: assert property (SDA_OUT == 1'b0)
        else $error("data pin driven high");
    chk_oe_scl_low: assert property ($changed(SDA_OE) |-> !SCL_IN)
        else $error("data drive changed with clock high");
    // reset load lands two edges after release, clock idles high then
    chk_code_scl_low: assert property (
        $changed(CH0_TARGET_CODE) && !$past(RST, 3) |-> !SCL_IN)
        else $error("target code changed outside a write");
endmodule // bbcc_top_chk

bind bbcc_top bbcc_top_chk u_chk (.CLOCK(CLOCK), .RST(RST), .SCL_IN(SCL_IN),
    .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .OTP_CFG_A(OTP_CFG_A),
    .OTP_CFG_B(OTP_CFG_B), .SEQ_SLOT_ON(SEQ_SLOT_ON), .ONOFF_ON(ONOFF_ON),
    .CH0_ENABLE(CH0_ENABLE), .CH0_DISCHARGE(CH0_DISCHARGE),
    .CH0_TARGET_CODE(CH0_TARGET_CODE), .CH0_TARGET_MV(CH0_TARGET_MV));

// [bench/bbcc_top_bench.sv]
`timescale 1ns/100ps
`include "bbcc_map.svh"
module bbcc_top_bench;
    // low phase is two half periods, leaving the sync pipeline room
    localparam int H = 6;
    logic clk = 1'b0, rst = 1'b1, scl = 1'b1, sda_m = 1'b1, onoff = 1'b1;
    logic oe, en, dis, x;
    logic [7:0] otp_a = 8'h3F;
    logic [3:0] otp_b = 4'hB, seq = 4'h8;
    logic [5:0] code;
    logic [11:0] mv;
    wire sda = sda_m & ~oe;
    int error_cnt = 0, samples_checked = 0;
    bbcc_top uut (.CLOCK(clk), .RST(rst), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(),
        .SDA_OE(oe), .OTP_CFG_A(otp_a), .OTP_CFG_B(otp_b), .SEQ_SLOT_ON(seq),
        .ONOFF_ON(onoff), .CH0_ENABLE(en), .CH0_DISCHARGE(dis),
        .CH0_TARGET_CODE(code), .CH0_TARGET_MV(mv));
    always #2 clk = ~clk;
    ////////////////////////////////////////////////////////////////
    task automatic cyc(int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic cmp(logic [11:0] got, logic [11:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic bitx(logic b, output logic r);
        sda_m <= b;
        cyc(H);
        scl <= 1'b1;
        cyc(H);
        r = sda;
        scl <= 1'b0;
        cyc(H);
    endtask
    task automatic start;
        sda_m <= 1'b1;
        cyc(H);
        scl <= 1'b1;
        cyc(H);
        sda_m <= 1'b0;
        cyc(H);
        scl <= 1'b0;
        cyc(H);
    endtask
    task automatic stop;
        sda_m <= 1'b0;
        cyc(H);
        scl <= 1'b1;
        cyc(H);
        sda_m <= 1'b1;
        cyc(H);
    endtask
    // all ones means a read byte: master releases and then does not ack
    task automatic xb(logic [7:0] d, output logic [7:0] r);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], b);
            r[i] = b;
        end
        bitx(1'b1, b);
        if (d !== 8'hFF) cmp({11'h000, b}, 12'h000);
    endtask
    task automatic wreg(logic [7:0] ad, logic [7:0] d);
        logic [7:0] r;
        start;
        xb({`BBCC_DEV_ADDR, 1'b0}, r);
        xb(ad, r);
        xb(d, r);
        stop;
    endtask
    task automatic rreg(logic [7:0] ad, logic [7:0] m, logic [7:0] exp);
        logic [7:0] r;
        start;
        xb({`BBCC_DEV_ADDR, 1'b0}, r);
        xb(ad, r);
        start;
        xb({`BBCC_DEV_ADDR, 1'b1}, r);
        xb(8'hFF, r);
        stop;
        cmp({4'h0, r & m}, {4'h0, exp});
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        cyc(2);
        rst <= 1'b0;
        cyc(4);
        cmp(12'(code), 12'h03F);
        cmp(mv, 12'h947);
        cmp(12'(en), 12'h001);
        cmp(12'(dis), 12'h000);
        rreg(`BBCC_ADDR_CFG_B, 8'h0F, 8'h0B);
        for (int c = 0; c < 64; c++) begin
            wreg(`BBCC_ADDR_CFG_A, c[7:0]);
            cmp(12'(code), c[11:0]);
            cmp(mv, 12'h320 + 12'h019 * c[11:0]);
        end
        rreg(`BBCC_ADDR_CFG_A, 8'hFF, 8'h3F);
        // bias stays in normal power mode here; no bias select reaches this block
        for (int f = 0; f < 8; f++) begin
            wreg(`BBCC_ADDR_CFG_B, {4'h0, ~f[0], f[2:0]});
            for (int o = 0; o < 2; o++) begin
                onoff <= o[0];
                seq <= o[0] ? 4'h0 : 4'hD;
                cyc(4);
                x = f < 4 ? seq[f[1:0]] : (f > 5 && onoff);
                cmp(12'(en), 12'(x));
                cmp(12'(dis), {11'h000, ~f[0] & ~x});
            end
        end
        wreg(8'h30, 8'h5A);
        rreg(8'h30, 8'hFF, 8'h00);
        summarize;
    end
    initial begin
        cyc(90000);
        error_cnt++;
        summarize;
    end
endmodule // bbcc_top_bench
